//--- hw/swm_pkg.sv
package swm_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [5:0]  SWM_CFG_OFS     = 6'h1A;
  localparam logic [5:0]  SWM_CRC_OFS     = 6'h03;
  localparam logic [5:0]  SWM_CMP1_OFS    = 6'h1D;
  localparam logic [23:0] SWM_CFG_RESET   = 24'h000000;
  localparam logic [15:0] SWM_CRC_RESET   = 16'hFFFF;
  localparam logic [23:0] SWM_ZERO_WORD   = 24'h000000;

  // ---------------------------------------------------------------
  // Configuration field positions
  // ---------------------------------------------------------------
  localparam int SWM_B_DRT_SINK  = 16;
  localparam int SWM_B_DEPTH_HI  = 15;
  localparam int SWM_B_DEPTH_LO  = 14;
  localparam int SWM_B_DRT_SRC   = 13;
  localparam int SWM_B_INT_DYN   = 12;
  localparam int SWM_B_RUN       = 11;
  localparam int SWM_B_POLL      = 10;
  localparam int SWM_B_CRC_TRIG  = 9;
  localparam int SWM_B_WIN_HI    = 8;
  localparam int SWM_B_WIN_LO    = 5;
  localparam int SWM_B_SWRST     = 0;
  localparam logic [23:0] SWM_CFG_RW_MASK   = 24'h01FFFF;
  localparam logic [23:0] SWM_CFG_LIVE_MASK = 24'h000A01;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SWM_CLK_MHZ     = 25;
  localparam int SWM_WIN_UNIT_US = 64;
  localparam int SWM_WIN_UNIT_CYC = SWM_WIN_UNIT_US * SWM_CLK_MHZ;
  localparam int SWM_NUM_IN      = 24;
endpackage

//--- hw/swm_win_if.sv
`timescale 1ns/100ps
interface swm_win_if;
  logic       start;
  logic       enable;
  logic [3:0] code;
  logic       active;
  logic       done;

  modport ctrl  (output start, output enable, output code, input active, input done);
  modport timer (input start, input enable, input code, output active, output done);
endinterface

//--- hw/swm_win_timer.sv
`timescale 1ns/100ps
module swm_win_timer
  import swm_pkg::*;
#(
  parameter int UNIT_CYC = SWM_WIN_UNIT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  swm_win_if.timer  win
);
  typedef struct packed {
    logic        active;
    logic        done;
    logic [15:0] left;
  } swm_tmr_type;

  swm_tmr_type st_q;
  swm_tmr_type st_d;

  // Window length in 64 us units
  function automatic logic [5:0] swm_units(input logic [3:0] c);
    logic [5:0] u;
    u = 6'h08;
    if (c <= 4'h7) begin
      u = {2'b00, c} + 6'h01;
    end else if (c <= 4'hB) begin
      u = {2'b00, c} + {2'b00, c} - 6'h06;
    end else if (c == 4'hC) begin
      u = 6'h20;
    end
    return u;
  endfunction

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (!win.enable) begin
      st_d.active = 1'b0;
      st_d.left   = 16'h0000;
    end else if (win.start && !st_q.active) begin
      st_d.active = 1'b1; // R13
      st_d.left   = 16'(32'(swm_units(win.code)) * UNIT_CYC - 1);
    end else if (st_q.active) begin
      if (st_q.left == 16'h0000) begin
        st_d.active = 1'b0;
        st_d.done   = 1'b1;
      end else begin
        st_d.left = st_q.left - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign win.active = st_q.active;
  assign win.done   = st_q.done;
endmodule

//--- hw/swm_config_reg.sv
// How it works
// R01 - Sink 10/15 mA inputs derate to 2 mA on thermal warning unless bit 16 set.
// R02 - Source 10/15 mA inputs derate to 2 mA on thermal warning unless bit 13 set.
// R03 - Filter depth 0 takes every sample; 1-3 need 2-4 equal consecutive samples.
// R04 - Bit 12 picks static (0) or dynamic (1) interrupt pin scheme.
// R05 - Run bit 1 starts wetting current and polling; 0 holds device idle.
// R06 - Controller stops operation before reconfiguring, then restarts it.
// R07 - While running, run, CRC trigger, reset bit and compare config one stay writable.
// R08 - Bit 10 at 0 gives continuous mode; at 1 polling mode.
// R09 - Writing 1 to CRC trigger starts a checksum over all configuration bits.
// R10 - Checksum finish sets done flag, pulls interrupt low, stores result.
// R11 - CRC trigger bit clears itself once the checksum has run.
// R12 - Controller leaves configuration unchanged while the checksum runs.
// R13 - Active-time code maps to 64-512, 640-1024, 2048 or 512 microseconds.
// R14 - Register at 1Ah resets to zero; bits 23-17 read as zero.
// R15 - Writes to reserved bits are dropped; they keep reading zero.
`timescale 1ns/100ps
module swm_config_reg
  import swm_pkg::*;
#(
  parameter int UNIT_CYC = SWM_WIN_UNIT_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [5:0]             reg_addr,
  input  wire logic [23:0]            reg_wdata,
  output logic      [23:0]            reg_rdata,
  output logic                        other_wr_ok,
  output logic                        crc_start,
  input  wire logic                   crc_done,
  input  wire logic [15:0]            crc_value,
  input  wire logic                   flag_clr,
  output logic                        checksum_done_flag,
  output logic                        int_n,
  output logic                        int_dynamic,
  output logic                        soft_reset_req,
  input  wire logic                   thermal_warning,
  output logic                        derate_sink_2ma,
  output logic                        derate_source_2ma,
  output logic                        wetting_on,
  output logic                        poll_mode,
  input  wire logic                   poll_start,
  output logic                        sample_window,
  input  wire logic                   sample_strobe,
  input  wire logic [SWM_NUM_IN-1:0]  sample_in,
  output logic      [SWM_NUM_IN-1:0]  switch_state,
  output logic      [SWM_NUM_IN-1:0]  switch_update
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [23:0]                 cfg;
    logic [15:0]                 crc_res;
    logic                        crc_busy;
    logic                        crc_go;
    logic                        flag;
    logic [23:0]                 rdata;
    logic [SWM_NUM_IN-1:0]       last;
    logic [SWM_NUM_IN-1:0][1:0]  run_len;
    logic [SWM_NUM_IN-1:0]       state;
    logic [SWM_NUM_IN-1:0]       upd;
  } swm_state_type;

  swm_state_type st_q;
  swm_state_type st_d;

  swm_win_if win ();

  logic       running;
  logic [1:0] depth;
  logic       cfg_wr;
  logic       trig_set;

  logic [SWM_NUM_IN-1:0]      flt_same;
  logic [SWM_NUM_IN-1:0][1:0] flt_len;
  logic [SWM_NUM_IN-1:0]      flt_take;

  // ---------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------
  assign running  = st_q.cfg[SWM_B_RUN];
  assign depth    = st_q.cfg[SWM_B_DEPTH_HI:SWM_B_DEPTH_LO];
  assign cfg_wr   = reg_wr && (reg_addr == SWM_CFG_OFS);
  assign trig_set = cfg_wr && reg_wdata[SWM_B_CRC_TRIG];

  // ---------------------------------------------------------------
  // Active-time window
  // ---------------------------------------------------------------
  assign win.enable = running && st_q.cfg[SWM_B_POLL]; // R08
  assign win.start  = poll_start;
  assign win.code   = st_q.cfg[SWM_B_WIN_HI:SWM_B_WIN_LO]; // R13

  swm_win_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_win (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .win      (win.timer)
  );

  // ---------------------------------------------------------------
  // Detection filter, one slice per input
  // ---------------------------------------------------------------
  // The repeat count saturates at the deepest setting, so a long steady
  // input never wraps round and drops out of the accepted state
  for (genvar g = 0; g < SWM_NUM_IN; g++) begin : g_flt
    assign flt_same[g] = (sample_in[g] == st_q.last[g]);
    assign flt_len[g]  = !flt_same[g] ? 2'h0
                       : (st_q.run_len[g] == 2'h3) ? 2'h3
                       : st_q.run_len[g] + 2'h1;
    assign flt_take[g] = (flt_len[g] >= depth); // R03
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.crc_go = 1'b0;
    st_d.upd    = '0;

    // Reserved bits never take write data; live fields stay writable in run
    if (cfg_wr) begin
      if (running) begin
        st_d.cfg = (st_q.cfg & ~SWM_CFG_LIVE_MASK)
                 | (reg_wdata & SWM_CFG_LIVE_MASK); // R07
      end else begin
        st_d.cfg = reg_wdata & SWM_CFG_RW_MASK; // R14 R15
      end
      // Writing 0 to the trigger never cancels a checksum in flight
      st_d.cfg[SWM_B_CRC_TRIG] = st_q.cfg[SWM_B_CRC_TRIG];
    end

    // Checksum finish clears the trigger; a new trigger in that cycle wins
    if (crc_done && st_q.crc_busy) begin
      st_d.crc_busy            = 1'b0;
      st_d.cfg[SWM_B_CRC_TRIG] = 1'b0; // R11
      st_d.crc_res             = crc_value; // R10
    end
    if (trig_set) begin
      st_d.cfg[SWM_B_CRC_TRIG] = 1'b1; // R09
      st_d.crc_busy            = 1'b1;
      st_d.crc_go              = 1'b1;
    end

    // Done flag: set beats clear
    if (flag_clr) begin
      st_d.flag = 1'b0;
    end
    if (crc_done && st_q.crc_busy) begin
      st_d.flag = 1'b1; // R10
    end

    // Read data is registered one cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == SWM_CFG_OFS) begin
        st_d.rdata = st_q.cfg & SWM_CFG_RW_MASK; // R14
      end else if (reg_addr == SWM_CRC_OFS) begin
        st_d.rdata = {8'h00, st_q.crc_res};
      end else begin
        st_d.rdata = SWM_ZERO_WORD;
      end
    end

    // Idle device ignores samples so the filter restarts cleanly
    if (!running) begin
      st_d.run_len = '0;
    end else if (sample_strobe) begin
      st_d.last    = sample_in;
      st_d.run_len = flt_len;
      st_d.state   = (st_q.state & ~flt_take) | (sample_in & flt_take); // R03
      st_d.upd     = flt_take;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.cfg     <= SWM_CFG_RESET; // R14
      // Result register comes up all ones, not zero
      st_q.crc_res <= SWM_CRC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata          = st_q.rdata;
  // Other config registers stay frozen in run, except compare config one
  assign other_wr_ok        = reg_wr && !cfg_wr
                            && (!running || reg_addr == SWM_CMP1_OFS); // R07
  assign crc_start          = st_q.crc_go; // R09
  assign checksum_done_flag = st_q.flag;
  assign int_n              = ~st_q.flag; // R10
  assign int_dynamic        = st_q.cfg[SWM_B_INT_DYN]; // R04
  assign soft_reset_req     = st_q.cfg[SWM_B_SWRST];
  // Derating only matters while current flows
  assign derate_sink_2ma    = running && thermal_warning
                            && !st_q.cfg[SWM_B_DRT_SINK]; // R01
  assign derate_source_2ma  = running && thermal_warning
                            && !st_q.cfg[SWM_B_DRT_SRC]; // R02
  // In polling mode current flows only inside the active window
  assign wetting_on         = running && (!st_q.cfg[SWM_B_POLL] || win.active); // R05
  assign poll_mode          = st_q.cfg[SWM_B_POLL]; // R08
  assign sample_window      = win.active;
  assign switch_state       = st_q.state;
  assign switch_update      = st_q.upd;
endmodule

//--- tb/swm_config_reg_assertions.sv
`timescale 1ns/100ps
module swm_config_reg_assertions
  import swm_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [5:0]  reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic        crc_start,
  input wire logic        crc_done,
  input wire logic        checksum_done_flag,
  input wire logic        int_n,
  input wire logic        thermal_warning,
  input wire logic        derate_sink_2ma,
  input wire logic        derate_source_2ma,
  input wire logic        wetting_on,
  input wire logic        poll_mode,
  input wire logic        sample_window
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence trig_wr;
    reg_wr && reg_addr == SWM_CFG_OFS && reg_wdata[SWM_B_CRC_TRIG];
  endsequence
  sequence crc_run;
    crc_start ##[1:40] checksum_done_flag;
  endsequence
  AST_CRC_START: assert property (trig_wr |=> crc_start)
    else $error("checksum start missing");
  AST_CRC_SPAN: assert property (crc_start |-> crc_run)
    else $error("checksum never completed");
  AST_DONE_FLAG: assert property ($rose(checksum_done_flag) |-> $past(crc_done))
    else $error("flag set without done");
  AST_INT_LOW: assert property ($rose(checksum_done_flag) |-> ##[0:1] !int_n)
    else $error("interrupt not asserted");
  AST_SINK: assert property (derate_sink_2ma |-> thermal_warning)
    else $error("sink derate without warning");
  AST_SOURCE: assert property (derate_source_2ma |-> thermal_warning)
    else $error("source derate without warning");
  AST_RSVD: assert property ($past(reg_rd) |-> reg_rdata[23:17] == 7'h00)
    else $error("reserved bits read nonzero");
  AST_WIN_RUN: assert property ($rose(sample_window) |-> wetting_on && poll_mode)
    else $error("window outside polling run");
  AST_POLL_OFF: assert property ($fell(poll_mode) |=> !sample_window)
    else $error("window kept after continuous mode");
endmodule

//--- tb/swm_crc_model.sv
`timescale 1ns/100ps
module swm_crc_model #(
  parameter int          DLY = 5,
  parameter logic [15:0] VAL = 16'h5A3C
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        crc_start,
  output logic             crc_done,
  output logic      [15:0] crc_value
);
  int cnt;
  initial begin
    crc_done = 1'b0;
    crc_value = 16'h0000;
  end
  // Value only meaningful with done; it toggles otherwise so stale sampling shows
  always @(posedge core_clk) begin
    crc_done <= 1'b0;
    crc_value <= ~crc_value;
    if (!rst_n) begin
      cnt <= 0;
    end else if (crc_start) begin
      cnt <= DLY;
    end else if (cnt == 1) begin
      crc_done <= 1'b1;
      crc_value <= VAL;
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb;
  import swm_pkg::*;
  localparam int          UC   = 3;
  localparam logic [15:0] CRCV = 16'h5A3C;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, flag_clr = 0, thermal_warning = 0;
  logic poll_start = 0, sample_strobe = 0, rd_v = 0;
  logic other_wr_ok, crc_start, crc_done, checksum_done_flag, int_n, int_dynamic;
  logic soft_reset_req, derate_sink_2ma, derate_source_2ma, wetting_on, poll_mode;
  logic sample_window;
  logic [5:0]  reg_addr = 6'h00;
  logic [23:0] reg_wdata = 24'h000000, sample_in = 24'h000000, reg_rdata, r, e;
  logic [23:0] switch_state, switch_update;
  logic [15:0] crc_value;
  logic [23:0] exp_q[$];
  logic [3:0]  wc[5] = '{4'h0, 4'h7, 4'h8, 4'hC, 4'hF};
  int          wu[5] = '{1, 8, 10, 32, 8};
  int          errors = 0, comparisons = 0;

  swm_config_reg #(.UNIT_CYC(UC)) u_dut (
    .core_clk (core_clk), .rst_n (rst_n), .reg_wr (reg_wr), .reg_rd (reg_rd),
    .reg_addr (reg_addr), .reg_wdata (reg_wdata), .reg_rdata (reg_rdata),
    .other_wr_ok (other_wr_ok), .crc_start (crc_start), .crc_done (crc_done),
    .crc_value (crc_value), .flag_clr (flag_clr),
    .checksum_done_flag (checksum_done_flag),
    .int_n (int_n), .int_dynamic (int_dynamic), .soft_reset_req (soft_reset_req),
    .thermal_warning (thermal_warning), .derate_sink_2ma (derate_sink_2ma),
    .derate_source_2ma (derate_source_2ma), .wetting_on (wetting_on),
    .poll_mode (poll_mode), .poll_start (poll_start), .sample_window (sample_window),
    .sample_strobe (sample_strobe), .sample_in (sample_in),
    .switch_state (switch_state), .switch_update (switch_update)
  );
  swm_crc_model #(.VAL(CRCV)) u_crc (.core_clk, .rst_n, .crc_start, .crc_done, .crc_value);

  always #20 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // Read monitor
  // ------------------------------------------------------------
  always @(posedge core_clk) rd_v <= reg_rd;
  always @(negedge core_clk) if (rd_v === 1'b1) begin
    e = exp_q.pop_front();
    `CHK("rdata", e, reg_rdata)
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [23:0] d);
    @(negedge core_clk); reg_wr = 1'b1; reg_addr = SWM_CFG_OFS; reg_wdata = d;
    @(negedge core_clk); reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] x);
    @(negedge core_clk); reg_rd = 1'b1; reg_addr = a; exp_q.push_back(x);
    @(negedge core_clk); reg_rd = 1'b0;
  endtask
  task automatic strobe(input logic [23:0] u);
    @(negedge core_clk); sample_strobe = 1'b1;
    @(negedge core_clk); sample_strobe = 1'b0;
    `CHK("update", u, switch_update)
    @(negedge core_clk);
  endtask
  task automatic wo(input logic [5:0] a, input logic x);
    @(negedge core_clk); reg_wr = 1'b1; reg_addr = a;
    @(negedge core_clk);
    `CHK("wr_ok", x, other_wr_ok)
    reg_wr = 1'b0;
  endtask
  task automatic win(input logic [3:0] c, input int u);
    int n;
    n = 0;
    wr(24'h000000);
    wr({12'h000, 2'b11, 1'b0, c, 5'h00});
    @(negedge core_clk); poll_start = 1'b1;
    @(negedge core_clk); poll_start = 1'b0;
    repeat (u * UC + 20) begin
      if (sample_window === 1'b1) n++;
      @(negedge core_clk);
    end
    `CHK("window", u * UC, n)
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(84));
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    rd(SWM_CFG_OFS, SWM_CFG_RESET);
    rd(SWM_CRC_OFS, {8'h00, SWM_CRC_RESET});
    rd(6'h3F, 24'h000000);
    for (int i = 0; i < 3; i++) begin
      r = 24'($urandom);
      r[11] = 1'b0;
      r[9] = 1'b0;
      wr(r);
      `CHK("intmode", r[12], int_dynamic)
      `CHK("poll", r[10], poll_mode)
      rd(SWM_CFG_OFS, r & SWM_CFG_RW_MASK);
    end
    wo(6'h1B, 1'b1);
    wr(24'h000000);
    wr(24'h000800);
    `CHK("wet", 1'b1, wetting_on)
    wo(SWM_CMP1_OFS, 1'b1);
    wo(6'h1B, 1'b0);
    wr(24'h01FFFF);
    repeat (40) if (checksum_done_flag !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    `CHK("int", 1'b0, int_n)
    `CHK("flag", 1'b1, checksum_done_flag)
    `CHK("swrst", 1'b1, soft_reset_req)
    rd(SWM_CFG_OFS, 24'h000801);
    rd(SWM_CRC_OFS, {8'h00, CRCV});
    @(negedge core_clk); flag_clr = 1'b1;
    @(negedge core_clk); flag_clr = 1'b0;
    @(negedge core_clk);
    `CHK("int", 1'b1, int_n)
    `CHK("flag", 1'b0, checksum_done_flag)
    thermal_warning = 1'b1;
    @(negedge core_clk);
    `CHK("sink", 1'b1, derate_sink_2ma)
    `CHK("src", 1'b1, derate_source_2ma)
    wr(24'h000000);
    wr(24'h012800);
    `CHK("sink", 1'b0, derate_sink_2ma)
    `CHK("src", 1'b0, derate_source_2ma)
    thermal_warning = 1'b0;
    wr(24'h000000);
    wr(24'h004800);
    r = 24'($urandom) | 24'h000001;
    sample_in = r;
    strobe(~r);
    `CHK("state", 24'h000000, switch_state)
    strobe(24'hFFFFFF);
    `CHK("state", r, switch_state)
    wr(24'h000000);
    wr(24'h00C800);
    sample_in = ~r;
    repeat (3) strobe(24'h000000);
    strobe(24'hFFFFFF);
    `CHK("state", ~r, switch_state)
    wr(24'h000000);
    wr(24'h000800);
    sample_in = r;
    strobe(24'hFFFFFF);
    `CHK("state", r, switch_state)
    foreach (wc[i]) win(wc[i], wu[i]);
    wr(24'h000000);
    wr(24'h000D80);
    `CHK("wet", 1'b0, wetting_on)
    @(negedge core_clk); poll_start = 1'b1;
    @(negedge core_clk); poll_start = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK("wet", 1'b1, wetting_on)
    `CHK("window", 1'b1, sample_window)
    wr(24'h000000);
    @(negedge core_clk);
    `CHK("window", 1'b0, sample_window)
    `CHK("wet", 1'b0, wetting_on)
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    `CHK("state", 24'h000000, switch_state)
    rd(SWM_CFG_OFS, SWM_CFG_RESET);
    rd(SWM_CRC_OFS, {8'h00, SWM_CRC_RESET});
    @(negedge core_clk);
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    end_sim();
  end
endmodule
bind swm_config_reg swm_config_reg_assertions u_chk (
  .core_clk           (core_clk),
  .rst_n              (rst_n),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_rdata          (reg_rdata),
  .crc_start          (crc_start),
  .crc_done           (crc_done),
  .checksum_done_flag (checksum_done_flag),
  .int_n              (int_n),
  .thermal_warning    (thermal_warning),
  .derate_sink_2ma    (derate_sink_2ma),
  .derate_source_2ma  (derate_source_2ma),
  .wetting_on         (wetting_on),
  .poll_mode          (poll_mode),
  .sample_window      (sample_window)
);
